// ==== pkg/backdoor_unlock_pkg.sv ====
package backdoor_unlock_pkg;

  // ---------------------------------------------------------------------------
  // Address map
  // ---------------------------------------------------------------------------
  localparam logic [15:0] FLASH_BASE_ADDR   = 16'hF000;
  localparam logic [15:0] VECTOR_BLOCK_BASE = 16'hFE00;
  localparam logic [15:0] KEY_BASE_ADDR     = 16'hFFB0;
  localparam logic [15:0] NV_PROT_ADDR      = 16'hFFBD;
  localparam logic [15:0] NV_OPT_ADDR       = 16'hFFBF;
  localparam logic [15:0] CONFIG_REG_ADDR   = 16'h1823;
  localparam logic [15:0] PROTECT_REG_ADDR  = 16'h1824;

  // ---------------------------------------------------------------------------
  // Field layout
  // ---------------------------------------------------------------------------
  localparam int          KEY_BYTES        = 8;
  localparam logic [3:0]  KEY_LAST_INDEX   = 4'h7;
  localparam logic [3:0]  KEY_COUNT        = 4'h8;
  localparam int          BACKDOOR_PERMIT_POS = 7;
  localparam int          SEC_FIELD_LSB    = 0;
  localparam int          KEY_ACCESS_POS   = 5;
  localparam int          VEC_PROTECT_POS  = 0;
  localparam logic [1:0]  SEC_UNSECURED    = 2'h2;

  // ---------------------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------------------
  localparam logic [7:0]  CONFIG_RESET     = 8'h00;

  // ---------------------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic        valid;
    logic [15:0] addr;
    logic [7:0]  data;
    logic        from_debug;
    logic        from_secure;
  } bus_write_type;

  typedef struct packed {
    logic        start;
    logic [15:0] addr;
    logic [7:0]  data;
  } flash_cmd_type;

  typedef logic [KEY_BYTES-1:0][7:0] key_bytes_type;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_ENTRY,
    ST_CHECK
  } unlock_state_type;

endpackage : backdoor_unlock_pkg

// ==== verilog/key_entry_mem.sv ====
`timescale 1ns/1ps
module key_entry_mem #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8,
  parameter int AW    = 3
) (
  // Clock
  input  wire logic             sys_clk_i,
  // Write side
  input  wire logic             wr_en_i,
  input  wire logic [AW-1:0]    wr_idx_i,
  input  wire logic [WIDTH-1:0] wr_data_i,
  // Read side
  input  wire logic [AW-1:0]    rd_idx_i,
  output logic      [WIDTH-1:0] rd_data_o
);

  logic [WIDTH-1:0] mem_q [DEPTH];

  // Contents need no reset: an unlock needs eight in-order key writes, which rewrite every entry the check reads
  always_ff @(posedge sys_clk_i) begin
    if (wr_en_i) begin
      mem_q[wr_idx_i] <= wr_data_i;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    rd_data_o <= mem_q[rd_idx_i];
  end

endmodule : key_entry_mem

// ==== verilog/backdoor_unlock.sv ====
`timescale 1ns/1ps
// Contract
// - Key unlock is possible only while the backdoor permit bit of the option register is 1.
// - While key compare access is 1, writes to the eight key locations are compare values, not flash commands.
// - Clearing key compare access after eight matching bytes sets the security field to 1:0 until reset.
// - Key bytes are accepted only from code running in secure memory, never from debug commands.
// - The block protect register is written only by debug commands; application writes are ignored.
// - Application code cannot change protection, and unlock never alters stored protection, security or key.
// - Option and key locations sit in the 512-byte vector block, so its protection covers the key.
// - A blank check that finds the whole flash erased disengages security until reset.
// - Key locations are programmed with the ordinary flash program commands.
// - At reset the option and protect bytes are copied into the option and protect registers.
module backdoor_unlock
  import backdoor_unlock_pkg::*;
(
  // Clock and reset
  input  wire logic          sys_clk_i,
  input  wire logic          sys_rst_i,
  // CPU and debug writes
  input  wire bus_write_type bus_wr_i,
  // Nonvolatile contents
  input  wire logic [7:0]    nv_option_byte_i,
  input  wire logic [7:0]    nv_protect_byte_i,
  input  wire key_bytes_type stored_compare_key_i,
  // Blank check result
  input  wire logic          blank_check_done_i,
  input  wire logic          blank_check_erased_i,
  // Flash command path
  output flash_cmd_type      flash_cmd_o,
  // Status
  output logic [7:0]         flash_option_reg_o,
  output logic [7:0]         block_protect_reg_o,
  output logic [7:0]         flash_config_reg_o,
  output logic [1:0]         security_state_field_o,
  output logic               secured_o,
  output logic               key_check_busy_o
);

  // ---------------------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------------------
  logic       key_hit;
  logic       cfg_hit;
  logic       prot_hit;
  logic       flash_hit;
  logic       vec_block_hit;
  logic [2:0] key_off;
  logic       acc_q;
  logic       acc_set;
  logic       acc_clr;
  logic       permit;
  logic       vec_protected;

  assign key_off       = bus_wr_i.addr[2:0];
  assign flash_hit     = bus_wr_i.addr >= FLASH_BASE_ADDR;
  assign vec_block_hit = bus_wr_i.addr >= VECTOR_BLOCK_BASE;
  assign permit        = flash_option_reg_o[BACKDOOR_PERMIT_POS];
  assign vec_protected = block_protect_reg_o[VEC_PROTECT_POS];

  always_comb begin
    key_hit  = 1'b0;
    cfg_hit  = 1'b0;
    prot_hit = 1'b0;
    if (!bus_wr_i.valid) begin
      key_hit = 1'b0;
    end else if (bus_wr_i.addr[15:3] == KEY_BASE_ADDR[15:3]) begin
      key_hit = 1'b1;
    end else if (bus_wr_i.addr == CONFIG_REG_ADDR) begin
      cfg_hit = 1'b1;
    end else if (bus_wr_i.addr == PROTECT_REG_ADDR) begin
      prot_hit = 1'b1;
    end
  end

  // Key access is set only by secure code and only when permitted
  assign acc_set = cfg_hit && bus_wr_i.from_secure && !bus_wr_i.from_debug
                   && bus_wr_i.data[KEY_ACCESS_POS] && permit;
  assign acc_clr = cfg_hit && !bus_wr_i.data[KEY_ACCESS_POS];

  // ---------------------------------------------------------------------------
  // Option, protect and config registers
  // ---------------------------------------------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      flash_option_reg_o <= nv_option_byte_i;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      block_protect_reg_o <= nv_protect_byte_i;
    end else if (prot_hit && bus_wr_i.from_debug) begin
      block_protect_reg_o <= bus_wr_i.data;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      acc_q <= CONFIG_RESET[KEY_ACCESS_POS];
    end else if (acc_set) begin
      acc_q <= 1'b1;
    end else if (acc_clr) begin
      acc_q <= 1'b0;
    end
  end

  always_comb begin
    flash_config_reg_o                 = CONFIG_RESET;
    flash_config_reg_o[KEY_ACCESS_POS] = acc_q;
  end

  // ---------------------------------------------------------------------------
  // Flash command path
  // ---------------------------------------------------------------------------
  // Protected vector block refuses commands, which also shields option and key
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      flash_cmd_o <= '0;
    end else begin
      flash_cmd_o.start <= bus_wr_i.valid && flash_hit && !(key_hit && acc_q)
                           && !(vec_block_hit && vec_protected);
      flash_cmd_o.addr  <= bus_wr_i.addr;
      flash_cmd_o.data  <= bus_wr_i.data;
    end
  end

  // ---------------------------------------------------------------------------
  // Key entry sequencing
  // ---------------------------------------------------------------------------
  unlock_state_type state_q;
  logic [3:0]       entry_cnt_q;
  logic             seq_bad_q;
  logic             last_key_wr_q;
  logic             key_wr;
  logic [3:0]       chk_idx_q;
  logic             mismatch_q;
  logic [7:0]       entered_byte;
  logic             chk_done;

  assign key_wr   = key_hit && acc_q && state_q == ST_ENTRY;
  assign chk_done = state_q == ST_CHECK && chk_idx_q == KEY_COUNT;

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      state_q <= ST_IDLE;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (acc_set) begin
            state_q <= ST_ENTRY;
          end
        end
        ST_ENTRY: begin
          if (acc_clr) begin
            state_q <= ST_CHECK;
          end
        end
        ST_CHECK: begin
          if (chk_done) begin
            state_q <= ST_IDLE;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // Out of order, adjacent-cycle or non-secure key writes spoil the attempt
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i || acc_set) begin
      entry_cnt_q   <= 4'h0;
      seq_bad_q     <= 1'b0;
      last_key_wr_q <= 1'b0;
    end else begin
      last_key_wr_q <= key_wr;
      if (key_wr) begin
        if (entry_cnt_q > KEY_LAST_INDEX || {1'b0, key_off} != entry_cnt_q) begin
          seq_bad_q <= 1'b1;
        end
        if (last_key_wr_q) begin
          seq_bad_q <= 1'b1;
        end
        if (bus_wr_i.from_debug || !bus_wr_i.from_secure) begin
          seq_bad_q <= 1'b1;
        end
        if (entry_cnt_q <= KEY_LAST_INDEX) begin
          entry_cnt_q <= entry_cnt_q + 4'h1;
        end
      end
    end
  end

  key_entry_mem #(
    .WIDTH (8),
    .DEPTH (KEY_BYTES),
    .AW    (3)
  ) u_key_mem (
    .sys_clk_i (sys_clk_i),
    .wr_en_i   (key_wr),
    .wr_idx_i  (key_off),
    .wr_data_i (bus_wr_i.data),
    .rd_idx_i  (chk_idx_q[2:0]),
    .rd_data_o (entered_byte)
  );

  // ---------------------------------------------------------------------------
  // Compare walk, one byte a cycle; read data lag the index by one
  // ---------------------------------------------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i || state_q != ST_CHECK) begin
      chk_idx_q  <= 4'h0;
      mismatch_q <= 1'b0;
    end else if (!chk_done) begin
      chk_idx_q <= chk_idx_q + 4'h1;
      if (chk_idx_q != 4'h0 && entered_byte != stored_compare_key_i[chk_idx_q[2:0] - 3'h1]) begin
        mismatch_q <= 1'b1;
      end
    end
  end

  logic last_ok;
  assign last_ok = entered_byte == stored_compare_key_i[KEY_LAST_INDEX[2:0]];

  // ---------------------------------------------------------------------------
  // Security state, volatile only
  // ---------------------------------------------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      security_state_field_o <= nv_option_byte_i[SEC_FIELD_LSB +: 2];
    end else if (blank_check_done_i && blank_check_erased_i) begin
      security_state_field_o <= SEC_UNSECURED;
    end else if (chk_done && !mismatch_q && last_ok && !seq_bad_q
                 && entry_cnt_q == KEY_COUNT && permit) begin
      security_state_field_o <= SEC_UNSECURED;
    end
  end

  assign secured_o        = security_state_field_o != SEC_UNSECURED;
  assign key_check_busy_o = state_q == ST_CHECK;

endmodule : backdoor_unlock

// ==== verif/backdoor_unlock_sva.sv ====
`timescale 1ns/1ps
module backdoor_unlock_sva
  import backdoor_unlock_pkg::*;
(
  // Inputs
  input wire logic          sys_clk_i,
  input wire logic          sys_rst_i,
  input wire bus_write_type bus_wr_i,
  input wire logic [7:0]    nv_option_byte_i,
  input wire logic [7:0]    nv_protect_byte_i,
  input wire logic          blank_check_done_i,
  input wire logic          blank_check_erased_i,
  // Outputs
  input wire flash_cmd_type flash_cmd_o,
  input wire logic [7:0]    flash_option_reg_o,
  input wire logic [7:0]    block_protect_reg_o,
  input wire logic [7:0]    flash_config_reg_o,
  input wire logic [1:0]    security_state_field_o
);
  // ----
  // Checks
  // ----
  logic key_wr;
  logic prot_wr;
  assign key_wr  = bus_wr_i.valid && bus_wr_i.addr[15:3] == KEY_BASE_ADDR[15:3];
  assign prot_wr = bus_wr_i.valid && bus_wr_i.addr == PROTECT_REG_ADDR;
  default clocking cb @(posedge sys_clk_i); endclocking
  opt_copy_a: assert property (sys_rst_i |=> flash_option_reg_o == $past(nv_option_byte_i))
    else $error("option copy wrong");
  prot_copy_a: assert property (sys_rst_i |=> block_protect_reg_o == $past(nv_protect_byte_i))
    else $error("protect copy wrong");
  blank_unlock_a: assert property (disable iff (sys_rst_i)
    blank_check_done_i && blank_check_erased_i |=> security_state_field_o == SEC_UNSECURED) else $error("no unlock");
  unsec_hold_a: assert property (disable iff (sys_rst_i)
    security_state_field_o == SEC_UNSECURED |=> security_state_field_o == SEC_UNSECURED) else $error("relocked");
  app_prot_a: assert property (disable iff (sys_rst_i)
    prot_wr && !bus_wr_i.from_debug |=> $stable(block_protect_reg_o)) else $error("app changed protect");
  dbg_prot_a: assert property (disable iff (sys_rst_i)
    prot_wr && bus_wr_i.from_debug |=> block_protect_reg_o == $past(bus_wr_i.data)) else $error("debug write lost");
  key_cmp_a: assert property (disable iff (sys_rst_i)
    key_wr && flash_config_reg_o[KEY_ACCESS_POS] |=> !flash_cmd_o.start) else $error("key write made command");
  vec_prot_a: assert property (disable iff (sys_rst_i) bus_wr_i.valid && bus_wr_i.addr >= VECTOR_BLOCK_BASE
    && block_protect_reg_o[VEC_PROTECT_POS] |=> !flash_cmd_o.start) else $error("protected block written");
  permit_a: assert property (disable iff (sys_rst_i) $rose(flash_config_reg_o[KEY_ACCESS_POS])
    |-> flash_option_reg_o[BACKDOOR_PERMIT_POS]) else $error("access without permit");
  opt_fixed_a: assert property (disable iff (sys_rst_i) 1'b1 |=> $stable(flash_option_reg_o))
    else $error("option changed");
  cover property (disable iff (sys_rst_i) $changed(security_state_field_o));
  cover property (disable iff (sys_rst_i) key_wr && flash_config_reg_o[KEY_ACCESS_POS]);
  cover property (disable iff (sys_rst_i) prot_wr && bus_wr_i.from_debug);
endmodule : backdoor_unlock_sva
bind backdoor_unlock backdoor_unlock_sva chk (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .bus_wr_i(bus_wr_i),
  .nv_option_byte_i(nv_option_byte_i), .nv_protect_byte_i(nv_protect_byte_i), .flash_cmd_o(flash_cmd_o),
  .blank_check_done_i(blank_check_done_i), .blank_check_erased_i(blank_check_erased_i),
  .flash_option_reg_o(flash_option_reg_o), .block_protect_reg_o(block_protect_reg_o),
  .flash_config_reg_o(flash_config_reg_o), .security_state_field_o(security_state_field_o));

// ==== verif/flash_nv_model.sv ====
`timescale 1ns/1ps
module flash_nv_model
  import backdoor_unlock_pkg::*;
(
  // Setup
  input  wire logic       sys_clk_i,
  input  wire logic [7:0] opt_i,
  input  wire logic [7:0] prot_i,
  input  wire logic       blank_req_i,
  input  wire logic       erased_i,
  // Toward device
  output logic [7:0]      nv_option_byte_o,
  output logic [7:0]      nv_protect_byte_o,
  output key_bytes_type   key_o,
  output logic            done_o,
  output logic            erased_o
);
  logic [2:0] cnt_q = 3'h0;
  assign nv_option_byte_o  = opt_i;
  assign nv_protect_byte_o = prot_i;
  always_comb for (int i = 0; i < KEY_BYTES; i++) key_o[i] = 8'h3C ^ 8'(i);
  always_ff @(posedge sys_clk_i) begin
    if (blank_req_i) cnt_q <= 3'h4;
    else if (cnt_q != 3'h0) cnt_q <= cnt_q - 3'h1;
  end
  assign done_o   = cnt_q == 3'h1;
  // Result is garbage outside the done pulse
  assign erased_o = done_o ? erased_i : ~erased_i;
endmodule : flash_nv_model

// ==== verif/backdoor_unlock_tb.sv ====
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin fail_count++; $display("[ERR] %0t got %h", $time, a); end end
module backdoor_unlock_tb;
  import backdoor_unlock_pkg::*;
  typedef struct packed {logic [15:0] a; logic [7:0] d; logic s;} row_type;
  logic          sys_clk_i = 1'b0;
  logic          sys_rst_i = 1'b1;
  bus_write_type bus_wr    = '0;
  logic [7:0]    opt       = 8'h80;
  logic [7:0]    prot      = 8'h00;
  logic          req       = 1'b0;
  logic          erased    = 1'b1;
  logic [7:0]    nv_opt, nv_prot, flash_option_reg, block_protect_reg, fcfg;
  key_bytes_type key;
  logic          bc_done, bc_erased, secured, busy;
  flash_cmd_type cmd;
  logic [1:0]    sec;
  int            fail_count = 0;
  int            checked    = 0;
  row_type       rows [4]   = '{'{16'hF000, 8'h11, 1'b1}, '{KEY_BASE_ADDR, 8'h22, 1'b1},
                                '{VECTOR_BLOCK_BASE, 8'h33, 1'b1}, '{CONFIG_REG_ADDR, 8'h00, 1'b0}};
  always #20 sys_clk_i = ~sys_clk_i;
  flash_nv_model nv (.sys_clk_i(sys_clk_i), .opt_i(opt), .prot_i(prot), .blank_req_i(req), .erased_i(erased),
    .nv_option_byte_o(nv_opt), .nv_protect_byte_o(nv_prot), .key_o(key), .done_o(bc_done), .erased_o(bc_erased));
  backdoor_unlock dut (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .bus_wr_i(bus_wr), .nv_option_byte_i(nv_opt),
    .nv_protect_byte_i(nv_prot), .stored_compare_key_i(key), .blank_check_done_i(bc_done),
    .blank_check_erased_i(bc_erased), .flash_cmd_o(cmd), .flash_option_reg_o(flash_option_reg), .block_protect_reg_o(block_protect_reg),
    .flash_config_reg_o(fcfg), .security_state_field_o(sec), .secured_o(secured), .key_check_busy_o(busy));
  task automatic finish_test();
    $display("checked %0d, failed %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : finish_test
  task automatic rst(input logic [7:0] o, input logic [7:0] p);
    opt = o;
    prot = p;
    sys_rst_i = 1'b1;
    repeat (6) @(posedge sys_clk_i);
    #1 sys_rst_i = 1'b0;
  endtask : rst
  task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic dbg, input logic s);
    @(posedge sys_clk_i);
    #1 bus_wr = '{1'b1, a, d, dbg, s};
    @(posedge sys_clk_i);
    #1 bus_wr.valid = 1'b0;
  endtask : wr
  // Spoiled byte 5 by bad; dbg sends key bytes as debug commands; rev writes them top down
  task automatic unlock(input logic [7:0] bad, input logic dbg, input logic rev);
    int n;
    int k;
    wr(CONFIG_REG_ADDR, 8'h20, 1'b0, 1'b1);
    for (int i = 0; i < KEY_BYTES; i++) begin
      k = rev ? KEY_BYTES - 1 - i : i;
      wr(KEY_BASE_ADDR + 16'(k), 8'h3C ^ 8'(k) ^ (k == 5 ? bad : 8'h00), dbg, !dbg);
      `CHK(cmd.start, 1'b0)
    end
    wr(CONFIG_REG_ADDR, 8'h00, 1'b0, 1'b1);
    n = 0;
    while (n < 20 && busy !== 1'b0) begin
      @(posedge sys_clk_i);
      #1 n++;
    end
    `CHK(n, int'(KEY_COUNT) + 1)
  endtask : unlock
  initial begin
    rst(8'h80, 8'h00);
    `CHK(flash_option_reg, 8'h80)
    `CHK(secured, 1'b1)
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d, 1'b0, 1'b1);
      `CHK(cmd.start, rows[i].s)
      if (rows[i].s) `CHK({cmd.addr, cmd.data}, {rows[i].a, rows[i].d})
    end
    $display("rows done");
    unlock(8'h01, 1'b0, 1'b0);
    `CHK(sec, 2'h0)
    unlock(8'h00, 1'b1, 1'b0);
    `CHK(sec, 2'h0)
    unlock(8'h00, 1'b0, 1'b1);
    `CHK(sec, 2'h0)
    unlock(8'h00, 1'b0, 1'b0);
    `CHK(sec, SEC_UNSECURED)
    `CHK(secured, 1'b0)
    $display("key entry done");
    rst(8'h00, 8'h01);
    `CHK(secured, 1'b1)
    `CHK(block_protect_reg, 8'h01)
    wr(CONFIG_REG_ADDR, 8'h20, 1'b0, 1'b1);
    `CHK(fcfg, 8'h00)
    wr(VECTOR_BLOCK_BASE, 8'h55, 1'b0, 1'b1);
    `CHK(cmd.start, 1'b0)
    wr(KEY_BASE_ADDR, 8'h5A, 1'b0, 1'b1);
    `CHK(cmd.start, 1'b0)
    wr(PROTECT_REG_ADDR, 8'h00, 1'b0, 1'b1);
    `CHK(block_protect_reg, 8'h01)
    wr(PROTECT_REG_ADDR, 8'h00, 1'b1, 1'b0);
    `CHK(block_protect_reg, 8'h00)
    $display("protect done");
    for (int e = 0; e < 2; e++) begin
      erased = e[0];
      req = 1'b1;
      @(posedge sys_clk_i);
      #1 req = 1'b0;
      repeat (6) @(posedge sys_clk_i);
      #1 `CHK(secured, !e[0])
    end
    rst(8'h02, 8'h00);
    `CHK(secured, 1'b0)
    $display("blank check done");
    finish_test();
  end
  initial begin
    #200000;
    fail_count++;
    finish_test();
  end
endmodule : backdoor_unlock_tb
